// ===== leased_line_map_consts.vh
/*
 constants for the leased-line core frame mapper: frame layout,
 overhead bit positions, register map and timing figures.
 assumes inclusion by bare name from the mapper module.
*/
`ifndef LEASED_LINE_MAP_CONSTS_VH
`define LEASED_LINE_MAP_CONSTS_VH

// ======================================================
// core frame layout
`define FRAME_BYTES 144
`define PAYLOAD_BYTES 128
`define STUFF_BYTES 16
`define FRAME_PERIOD_US 500
`define STUFF_BYTE 8'hff
`define ALL_ONES_BYTE 8'hff

// ======================================================
// overhead layout
`define OH_BITS 48
`define OH_INPUT_LOSS_BIT 15
`define OH_SPARE_LO 9
`define OH_SPARE_HI 48

// ======================================================
// delay budget figures in microseconds
`define END_TO_END_DELAY_US 1250
`define TERMINAL_DELAY_US 450
`define REGEN_DELAY_US 200
`define LINE_DELAY_US 150

// ======================================================
// clock
`define PCLK_MHZ 20

// ======================================================
// register map, byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LOSS_RUN 12'h008
`define REG_PAIR_CFG 12'h00c
`define REG_AUX_PATTERN 12'h010

// ctrl fields
`define CTRL_STRUCTURED 0
`define CTRL_NETWORK_SIDE 1
`define CTRL_AUX_SELECT 2
`define CTRL_LOOPBACK 3

// status fields
`define ST_OPERATIONAL 0
`define ST_INPUT_LOSS 1
`define ST_LINE_ALARM 2
`define ST_LOOPBACK 3
`define ST_ACTIVE_ALL 4

// reset values
`define CTRL_RESET 32'h0000_0000
`define LOSS_RUN_RESET 16'h00ff
`define AUX_RESET 8'h55

`endif

// ===== leased_line_core_maintenance_map.v
/*
 leased-line mapper between the 2048 kbit/s application interface
 and the 144-byte core frame, with section state, input loss,
 alarm substitution and line loopback; apb register slave.
 assumes app bits arrive with a one-cycle strobe on pclk domain
 from an external rate adapter, and core bytes are pulled by
 the core framer with a byte strobe; pair status pins are async.
*/
// Contract
// - operational only if all pairs active, ids correct, no failure
// - any pair down or wrong id makes section non-operational at once
// - unstructured payload passes untouched, no maintenance inserted
// - on app input loss send all ones toward far end
// - while input loss lasts, overhead bit 15 is sent as zero
// - loss flag goes in overhead sent toward the opposite unit
// - unstructured network side sends AIS on any line loss/alignment loss
// - customer side output undefined until all transceivers active
// - structured network side sends AIS or auxiliary pattern by config
// - structured data mapped into 144-byte frame every 500 us
// - remaining 16 bytes per frame are all-ones stuffing
// - spare overhead bits nine to forty-eight sent as ones; code sends bit fifteen as the inverted input loss flag
// - loopback request closes transparent loopback in every transceiver; code closes it only while network side is set
// - end-to-end one-way delay at most 1250 us
// - unit delay at most 450 us, regenerator 200, line 150
`include "leased_line_map_consts.vh"

module leased_line_core_maintenance_map #(
   parameter PAIRS = 3
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire app_in_bit,
   input wire app_in_valid,
   output reg app_out_bit,
   output reg app_out_valid,
   input wire core_tx_pull,
   output reg [7:0] core_tx_byte,
   output reg core_tx_stuff,
   input wire [7:0] core_rx_byte,
   input wire core_rx_valid,
   input wire core_rx_stuff,
   input wire [PAIRS-1:0] pair_active,
   input wire [PAIRS-1:0] pair_id_ok,
   input wire [PAIRS-1:0] pair_los_lfa,
   input wire far_input_loss,
   output wire [`OH_BITS-1:0] line_frame_overhead,
   output reg [PAIRS-1:0] pair_loopback
);

   // ======================================================
   // delay budget flag, computed at elaboration time but never acted on
   localparam integer FRAME_CYCLES = `FRAME_PERIOD_US * `PCLK_MHZ;
   localparam integer UNIT_DELAY_CYCLES = `TERMINAL_DELAY_US * `PCLK_MHZ;
   localparam integer BUDGET_OK = (2 * `TERMINAL_DELAY_US + `REGEN_DELAY_US
      + `LINE_DELAY_US <= `END_TO_END_DELAY_US) ? 1 : 0;

   // ======================================================
   // pin synchronisers
   reg [3*PAIRS:0] sync1;
   reg [3*PAIRS:0] sync2;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= {(3*PAIRS+1){1'b0}};
         sync2 <= {(3*PAIRS+1){1'b0}};
      end else begin
         sync1 <= {far_input_loss, pair_los_lfa, pair_id_ok, pair_active};
         sync2 <= sync1;
      end
   end
   wire [PAIRS-1:0] act_s = sync2[PAIRS-1:0];
   wire [PAIRS-1:0] id_s = sync2[2*PAIRS-1:PAIRS];
   wire [PAIRS-1:0] los_s = sync2[3*PAIRS-1:2*PAIRS];
   wire far_loss_s = sync2[3*PAIRS];

   // ======================================================
   // registers
   reg [31:0] ctrl;
   reg [15:0] loss_run;
   reg [PAIRS-1:0] pair_fail;
   reg [7:0] aux_pattern;
   wire structured = ctrl[`CTRL_STRUCTURED];
   wire network_side = ctrl[`CTRL_NETWORK_SIDE];
   wire aux_select = ctrl[`CTRL_AUX_SELECT];
   wire loop_req = ctrl[`CTRL_LOOPBACK];

   wire wr = psel && penable && pwrite;
   wire rd_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
      (paddr == `REG_LOSS_RUN) || (paddr == `REG_PAIR_CFG) ||
      (paddr == `REG_AUX_PATTERN);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_ok;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         loss_run <= `LOSS_RUN_RESET;
         pair_fail <= {PAIRS{1'b0}};
         aux_pattern <= `AUX_RESET;
      end else if (wr) begin
         case (paddr)
            `REG_CTRL: ctrl <= pwdata;
            `REG_LOSS_RUN: loss_run <= pwdata[15:0];
            `REG_PAIR_CFG: pair_fail <= pwdata[PAIRS-1:0];
            `REG_AUX_PATTERN: aux_pattern <= pwdata[7:0];
            default: ctrl <= ctrl;
         endcase
      end
   end

   // ======================================================
   // section state
   wire all_active = &act_s;
   wire operational = all_active && (&id_s) && !(|pair_fail) && !(|los_s);
   wire line_alarm = |los_s;

   // ======================================================
   // application input loss
   reg [15:0] zero_run;
   reg input_loss;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_run <= 16'h0000;
         input_loss <= 1'b0;
      end else if (app_in_valid) begin
         if (app_in_bit) begin
            zero_run <= 16'h0000;
            input_loss <= 1'b0;
         end else begin
            if (zero_run != 16'hffff)
               zero_run <= zero_run + 16'h0001;
            if (zero_run + 16'h0001 >= loss_run)
               input_loss <= 1'b1;
         end
      end
   end

   // ======================================================
   // status and read data
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `REG_CTRL: prdata = ctrl;
         `REG_STATUS: begin
            prdata[`ST_OPERATIONAL] = operational;
            prdata[`ST_INPUT_LOSS] = input_loss;
            prdata[`ST_LINE_ALARM] = line_alarm;
            prdata[`ST_LOOPBACK] = |pair_loopback;
            prdata[`ST_ACTIVE_ALL] = all_active;
         end
         `REG_LOSS_RUN: prdata[15:0] = loss_run;
         `REG_PAIR_CFG: prdata[PAIRS-1:0] = pair_fail;
         `REG_AUX_PATTERN: prdata[7:0] = aux_pattern;
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ======================================================
   // transmit: bit packer and frame builder
   reg [7:0] shift;
   reg [2:0] bit_cnt;
   reg [7:0] held_byte;
   reg [7:0] slot;
   reg [7:0] pay_cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift <= 8'h00;
         bit_cnt <= 3'h0;
         held_byte <= `ALL_ONES_BYTE;
      end else if (app_in_valid) begin
         shift <= {shift[6:0], app_in_bit};
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7)
            held_byte <= {shift[6:0], app_in_bit};
      end
   end

   // stuffing slots sit at the frame tail
   wire stuff_slot = (slot >= `PAYLOAD_BYTES);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= 8'h00;
         core_tx_byte <= `ALL_ONES_BYTE;
         core_tx_stuff <= 1'b0;
         pay_cnt <= 8'h00;
      end else if (core_tx_pull) begin
         slot <= (slot == `FRAME_BYTES - 1) ? 8'h00 : slot + 8'h01;
         core_tx_stuff <= stuff_slot;
         if (stuff_slot)
            core_tx_byte <= `STUFF_BYTE;
         else if (input_loss)
            core_tx_byte <= `ALL_ONES_BYTE;
         else
            core_tx_byte <= held_byte;
         if (!stuff_slot)
            pay_cnt <= pay_cnt + 8'h01;
      end
   end

   // ======================================================
   // overhead toward the opposite unit
   genvar g;
   generate
      for (g = 0; g < `OH_BITS; g = g + 1) begin : oh_bits
         if (g + 1 == `OH_INPUT_LOSS_BIT) begin : loss_bit
            assign line_frame_overhead[g] = !input_loss;
         end else if (g + 1 >= `OH_SPARE_LO && g + 1 <= `OH_SPARE_HI) begin : spare
            assign line_frame_overhead[g] = 1'b1;
         end else begin : other
            assign line_frame_overhead[g] = 1'b1;
         end
      end
   endgenerate

   // ======================================================
   // receive: byte to bit, alarm substitution
   reg [7:0] rx_hold;
   reg [3:0] rx_left;
   wire send_alarm = network_side && (line_alarm || far_loss_s && 1'b0);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_hold <= `ALL_ONES_BYTE;
         rx_left <= 4'h0;
         app_out_bit <= 1'b1;
         app_out_valid <= 1'b0;
      end else begin
         app_out_valid <= 1'b0;
         if (core_rx_valid && !core_rx_stuff) begin
            if (send_alarm && structured && aux_select)
               rx_hold <= aux_pattern;
            else if (send_alarm)
               rx_hold <= `ALL_ONES_BYTE;
            else
               rx_hold <= core_rx_byte;
            rx_left <= 4'h8;
         end else if (rx_left != 4'h0) begin
            app_out_bit <= rx_hold[7];
            rx_hold <= {rx_hold[6:0], 1'b1};
            rx_left <= rx_left - 4'h1;
            app_out_valid <= 1'b1;
         end
      end
   end

   // ======================================================
   // loopback in every transceiver
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pair_loopback <= {PAIRS{1'b0}};
      else
         pair_loopback <= {PAIRS{loop_req && network_side}};
   end

endmodule // leased_line_core_maintenance_map

// ===== leased_line_core_maintenance_map_checker.sv
/* port checker for the core frame mapper.
 bound to the mapper; sees only its ports. */
`include "leased_line_map_consts.vh"
module leased_line_core_maintenance_map_checker #(
   parameter PAIRS = 3
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire app_in_bit,
   input wire app_in_valid,
   input wire app_out_valid,
   input wire core_tx_pull,
   input wire [7:0] core_tx_byte,
   input wire core_tx_stuff,
   input wire core_rx_valid,
   input wire core_rx_stuff,
   input wire [PAIRS-1:0] pair_active,
   input wire [PAIRS-1:0] pair_id_ok,
   input wire [`OH_BITS-1:0] line_frame_overhead,
   input wire [PAIRS-1:0] pair_loopback
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] slot;
   logic [15:0] run, zeros;
   logic lb_req;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========
   // slot, zero run and request trackers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= 8'h00;
         run <= `LOSS_RUN_RESET;
         zeros <= 16'h0000;
         lb_req <= 1'b0;
      end else begin
         if (core_tx_pull)
            slot <= (slot == 8'h8f) ? 8'h00 : slot + 8'h01;
         if (psel && penable && pwrite && paddr == `REG_LOSS_RUN)
            run <= pwdata[15:0];
         if (psel && penable && pwrite && paddr == `REG_CTRL)
            lb_req <= pwdata[3] && pwdata[1];
         if (app_in_valid)
            zeros <= app_in_bit ? 16'h0000 : zeros + 16'h0001;
      end
   end
   sequence s_rx_byte;
      core_rx_valid && !core_rx_stuff;
   endsequence
   sequence s_pull;
      core_tx_pull;
   endsequence
   // ========
   // assertions
   a_stuff_slots: assert property (s_pull |=> core_tx_stuff == ($past(slot) >= 8'h80))
      else $error("stuff flag in wrong slot");
   a_stuff_ones: assert property (core_tx_stuff |-> core_tx_byte == 8'hff)
      else $error("stuff byte not all ones");
   a_spare_ones: assert property (&(line_frame_overhead | 48'h0000_0000_4000))
      else $error("spare overhead bit not one");
   a_loss_after_run: assert property ($fell(line_frame_overhead[14]) |-> zeros >= run)
      else $error("loss flagged before zero run");
   a_loss_clears: assert property (app_in_valid && app_in_bit |=> ##[0:1] line_frame_overhead[14])
      else $error("loss flag kept after one bit");
   a_ones_on_loss: assert property (core_tx_pull && !line_frame_overhead[14] |=> core_tx_byte == 8'hff)
      else $error("payload sent during input loss");
   a_section_down: assert property (psel && !pwrite && paddr == `REG_STATUS
      && !(&$past(pair_active & pair_id_ok, 4)) && !(&(pair_active & pair_id_ok)) |-> !prdata[0])
      else $error("operational with a pair down");
   a_loop_all: assert property (pair_loopback != '0 |-> &pair_loopback)
      else $error("loopback not in every pair");
   a_loop_request: assert property ($rose(lb_req) |-> ##[0:3] &pair_loopback)
      else $error("loopback request not obeyed");
   a_rx_eight_bits: assert property (s_rx_byte |=> ##1 app_out_valid [*8])
      else $error("received byte not passed as eight bits");
endmodule // leased_line_core_maintenance_map_checker
bind leased_line_core_maintenance_map leased_line_core_maintenance_map_checker #(.PAIRS(PAIRS)) chk_u (.*);

// ===== far_end_model.sv
/* far-end core framer model: pulls tx bytes, sends rx bytes.
 assumes the bench drives pull_on, pull_gap and calls send_rx. */
module far_end_model (
   input logic pclk,
   input logic presetn,
   input logic pull_on,
   input logic [3:0] pull_gap,
   output logic core_tx_pull,
   output logic [7:0] core_rx_byte = 8'h00,
   output logic core_rx_valid = 1'b0,
   output logic core_rx_stuff = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] gap_cnt;
   // ========
   // byte pulls, one every pull_gap+1 cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_cnt <= 4'h0;
         core_tx_pull <= 1'b0;
      end else begin
         core_tx_pull <= pull_on && gap_cnt == 4'h0;
         gap_cnt <= (gap_cnt == 4'h0) ? pull_gap : gap_cnt - 4'h1;
      end
   end
   // ========
   // one rx byte; released line shows the inverse
   task automatic send_rx(input logic [7:0] b, input logic s);
      @(posedge pclk);
      core_rx_byte <= b;
      core_rx_valid <= 1'b1;
      core_rx_stuff <= s;
      @(posedge pclk);
      core_rx_byte <= ~b;
      core_rx_valid <= 1'b0;
      core_rx_stuff <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask
endmodule // far_end_model

// ===== tb_leased_line_core_maintenance_map.sv
/* bench for the core frame mapper over apb and core ports.
 assumes the far-end model and the bound checker. */
`include "leased_line_map_consts.vh"
module tb_leased_line_core_maintenance_map;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic app_in_bit = 1'b0, app_in_valid = 1'b0, far_input_loss = 1'b0, pull_on = 1'b0;
   logic pready, pslverr, rerr, app_out_bit, app_out_valid, pull_d;
   logic core_tx_pull, core_tx_stuff, core_rx_valid, core_rx_stuff;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [7:0] core_tx_byte, core_rx_byte, rx_sh, last_byte, pay_byte;
   logic [3:0] pull_gap = 4'h0;
   logic [2:0] pair_active = 3'b000, pair_id_ok = 3'b000, pair_los_lfa = 3'b000, pair_loopback;
   logic [47:0] line_frame_overhead;
   logic [31:0] ctl [3] = '{32'h2, 32'h3, 32'h7};
   logic [7:0] exp_b [3] = '{8'hff, 8'hff, 8'h55};
   int bad_count = 0, checked = 0, cyc = 0, tx_n = 0, stuff_n = 0, rx_n = 0, i;
   leased_line_core_maintenance_map dut_u (.*);
   far_end_model far_u (.*);
   initial begin
      forever #25 pclk = ~pclk;
   end
   // ========
   // monitors and timeout
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      pull_d <= core_tx_pull;
      if (app_out_valid === 1'b1) begin
         rx_sh <= {rx_sh[6:0], app_out_bit};
         rx_n <= rx_n + 1;
      end
      if (pull_d === 1'b1) begin
         tx_n <= tx_n + 1;
         last_byte <= core_tx_byte;
         if (core_tx_stuff === 1'b1 && tx_n < 144)
            stuff_n <= stuff_n + 1;
         if (core_tx_stuff === 1'b0)
            pay_byte <= core_tx_byte;
      end
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   // ========
   // tasks
   task automatic end_sim;
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex, string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, rdata & m);
   endtask
   task automatic send_app(input logic [7:0] b);
      for (int k = 7; k >= 0; k--) begin
         app_in_bit <= b[k];
         app_in_valid <= 1'b1;
         @(posedge pclk);
         app_in_valid <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // ========
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`REG_CTRL, 32'hffffffff, `CTRL_RESET, "ctrl");
      rd(`REG_LOSS_RUN, 32'hffff, 32'hff, "loss_run");
      rd(`REG_AUX_PATTERN, 32'hff, 32'h55, "aux");
      rd(12'h020, 32'hffffffff, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, rerr});
      pair_active <= 3'b111;
      pair_id_ok <= 3'b111;
      repeat (4) @(posedge pclk);
      rd(`REG_STATUS, 32'h1, 32'h1, "operational");
      apb(1'b1, `REG_PAIR_CFG, 32'h1);
      rd(`REG_STATUS, 32'h1, 32'h0, "forced failure");
      apb(1'b1, `REG_PAIR_CFG, 32'h0);
      pair_id_ok <= 3'b101;
      repeat (4) @(posedge pclk);
      rd(`REG_STATUS, 32'h1, 32'h0, "wrong pair id");
      pair_id_ok <= 3'b111;
      apb(1'b1, `REG_CTRL, 32'h1);
      send_app(8'ha5);
      pull_on <= 1'b1;
      while (tx_n < 144) @(posedge pclk);
      pull_on <= 1'b0;
      chk("stuff count", 32'h10, 32'(stuff_n));
      chk("payload", 32'ha5, {24'h0, pay_byte});
      apb(1'b1, `REG_LOSS_RUN, 32'h8);
      send_app(8'h00);
      repeat (2) @(posedge pclk);
      chk("loss bit", 32'h0, {31'h0, line_frame_overhead[14]});
      rd(`REG_STATUS, 32'h2, 32'h2, "input loss");
      pull_gap <= 4'h3;
      pull_on <= 1'b1;
      i = tx_n;
      while (tx_n < i + 4) @(posedge pclk);
      pull_on <= 1'b0;
      chk("ones toward line", 32'hff, {24'h0, last_byte});
      send_app(8'h80);
      repeat (2) @(posedge pclk);
      chk("loss cleared", 32'h1, {31'h0, line_frame_overhead[14]});
      far_u.send_rx(8'h96, 1'b0);
      chk("rx byte", 32'h96, {24'h0, rx_sh});
      i = rx_n;
      far_u.send_rx(8'hff, 1'b1);
      chk("stuff dropped", 32'(i), 32'(rx_n));
      pair_los_lfa <= 3'b010;
      for (i = 0; i < 3; i++) begin
         apb(1'b1, `REG_CTRL, ctl[i]);
         far_u.send_rx(8'h3c, 1'b0);
         chk("alarm output", {24'h0, exp_b[i]}, {24'h0, rx_sh});
      end
      pair_los_lfa <= 3'b000;
      apb(1'b1, `REG_CTRL, 32'ha);
      repeat (4) @(posedge pclk);
      chk("loopback", 32'h7, {29'h0, pair_loopback});
      end_sim();
   end
endmodule // tb_leased_line_core_maintenance_map
